/* rtl/stes_core.sv */
// spi transfer engine with end-of-transfer status and interrupt status bits
`timescale 1ns/1ps
module stes_core #(
	parameter int WIDTH      = 8,
	parameter int RATIO      = 16,
	parameter int NUM_SS     = 1,
	parameter int SPI_MODE   = stes_pkg::MODE_STD,
	parameter bit MASTER     = 1'b1,
	parameter bit USE_FIFO   = 1'b0,
	parameter int FIFO_DEPTH = 8,
	parameter bit EXECUTE_IN_PLACE_MODE        = 1'b0,
	parameter int XIP_ABITS  = 24,
	parameter bit PERF_MODE  = 1'b0,
	parameter bit ASYNC_CLK  = 1'b0
) (
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire stes_pkg::stes_ctrl_t ctrl,
	input  wire logic [NUM_SS-1:0]   ss_select,
	input  wire logic [WIDTH-1:0]    tx_data,
	input  wire logic                tx_valid,
	output logic                     tx_ready,
	input  wire logic                rx_pop,
	input  wire logic [7:0]          isr_clear,
	output logic [WIDTH-1:0]         receive_data_register,
	output logic [3:0]               serial_status_register,
	output logic [7:0]               interrupt_status_register,
	output logic [4:0]               rx_occupancy,
	output logic                     transfer_done_flag,
	output logic                     sclk_o,
	output logic                     sclk_oe,
	output logic [NUM_SS-1:0]        ss_n_o,
	output logic                     mosi_o,
	output logic                     mosi_oe,
	input  wire logic                mosi_i,
	output logic                     miso_o,
	output logic                     miso_oe,
	input  wire logic                miso_i,
	input  wire logic                sclk_i,
	input  wire logic                ss_n_i
);
	localparam int BW = $clog2(WIDTH) + 1;
	localparam int DW = $clog2(RATIO);
	localparam int HALF = RATIO / 2;

	initial
	begin
		if (!(WIDTH == 8 || WIDTH == 16 || WIDTH == 32)) $error("bad width");
		if (SPI_MODE != stes_pkg::MODE_STD && WIDTH != 8) $error("dual/quad need width 8");
		if (RATIO < stes_pkg::MIN_RATIO || RATIO > stes_pkg::MAX_RATIO || (1 << DW) != RATIO)
			$error("bad ratio");
		if (SPI_MODE != stes_pkg::MODE_STD && RATIO != stes_pkg::MIN_RATIO) $error("ratio fixed at 2");
		if (NUM_SS < 1 || NUM_SS > stes_pkg::MAX_SLAVES || (EXECUTE_IN_PLACE_MODE && NUM_SS != 1)) $error("bad slaves");
		if (SPI_MODE != stes_pkg::MODE_STD && (!MASTER || !USE_FIFO)) $error("dual/quad: master with fifo");
		if (SPI_MODE != stes_pkg::MODE_STD && !(FIFO_DEPTH == 16 || FIFO_DEPTH == 256))
			$error("dual/quad fifo depth 16 or 256");
		if (EXECUTE_IN_PLACE_MODE && !(XIP_ABITS == 24 || XIP_ABITS == 32)) $error("bad xip address width");
		if (PERF_MODE && EXECUTE_IN_PLACE_MODE) $error("performance and xip port conflict");
		if (ASYNC_CLK) $error("single clock build: async option unsupported");
	end

	// tx words queue here; with or without the fifo option the buffer is FIFO_DEPTH deep
	logic [WIDTH-1:0] fifo_data;
	logic             fifo_valid;
	logic             fifo_pop;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	stes_fifo #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH)) u_txq (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.level     (fifo_level)
	);

	// three-stage sampling of slave-side pins
	logic [2:0] sck_s_reg, ss_s_reg, mosi_s_reg;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sck_s_reg  <= '0;
			ss_s_reg   <= 3'h7;
			mosi_s_reg <= '0;
		end
		else
		begin
			sck_s_reg  <= {sck_s_reg[1:0], sclk_i};
			ss_s_reg   <= {ss_s_reg[1:0], ss_n_i};
			mosi_s_reg <= {mosi_s_reg[1:0], mosi_i};
		end
	end
	logic sck_lvl, ss_act, s_fall, s_rise, ss_edge_on, ss_edge_off;
	logic sck_prev_reg, ss_prev_reg;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sck_prev_reg <= 1'b0;
			ss_prev_reg  <= 1'b0;
		end
		else
		begin
			if (sck_s_reg[2] == sck_s_reg[1]) sck_prev_reg <= sck_s_reg[2];
			if (ss_s_reg[2] == ss_s_reg[1]) ss_prev_reg <= !ss_s_reg[2];
		end
	end
	always_comb
	begin
		sck_lvl     = (sck_s_reg[2] == sck_s_reg[1]) ? sck_s_reg[2] : sck_prev_reg;
		ss_act      = (ss_s_reg[2] == ss_s_reg[1]) ? !ss_s_reg[2] : ss_prev_reg;
		s_rise      = sck_lvl && !sck_prev_reg;
		s_fall      = !sck_lvl && sck_prev_reg;
		ss_edge_on  = ss_act && !ss_prev_reg;
		ss_edge_off = !ss_act && ss_prev_reg;
	end

	stes_pkg::stes_state_t st_reg, st_next;
	logic [DW-1:0]    div_reg, div_next;
	logic [BW-1:0]    bit_reg, bit_next;
	logic             sck_reg, sck_next;
	logic [WIDTH-1:0] sh_reg, sh_next;
	logic [WIDTH-1:0] rdr_reg, rdr_next;
	logic [3:0]       sr_reg, sr_next;
	logic [7:0]       isr_reg, isr_next;
	logic [NUM_SS-1:0] ss_reg, ss_next;
	logic             first_reg, first_next;
	logic             in_bit_reg, in_bit_next;
	logic             half_prev_reg;
	logic [4:0]       occ_reg, occ_next;
	logic             done_reg, done_next;
	logic             tick, lead, trail, word_end, cfg_bad, tx_half;

	always_comb
	begin
		tick     = div_reg == DW'(HALF - 1);
		lead     = MASTER ? (tick && !sck_reg) : ((ss_act && !ctrl.clock_polarity_select) ? s_rise : s_fall);
		trail    = MASTER ? (tick && sck_reg) : ((ss_act && !ctrl.clock_polarity_select) ? s_fall : s_rise);
		cfg_bad  = SPI_MODE != stes_pkg::MODE_STD && ctrl.clock_phase_select != ctrl.clock_polarity_select;
		tx_half  = fifo_level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH / 2);
		st_next  = st_reg;
		// wrap on every tick so each half period is exactly RATIO/2 clocks
		div_next = (st_reg == stes_pkg::ST_IDLE || tick) ? '0 : div_reg + DW'(1);
		bit_next = bit_reg;
		sck_next = sck_reg;
		sh_next  = sh_reg;
		rdr_next = rdr_reg;
		sr_next  = sr_reg;
		isr_next = isr_reg & ~isr_clear;
		ss_next  = ss_reg;
		first_next = first_reg;
		in_bit_next = in_bit_reg;
		occ_next = occ_reg;
		done_next = 1'b0;
		fifo_pop = 1'b0;
		word_end = 1'b0;
		if (rx_pop && occ_reg != '0)
			occ_next = occ_reg - 5'h1;
		if (rx_pop && !USE_FIFO)
		begin
			sr_next[stes_pkg::SR_RX_FULL]  = 1'b0;
			sr_next[stes_pkg::SR_RX_EMPTY] = 1'b1;
		end
		case (st_reg)
			stes_pkg::ST_IDLE:
			begin
				if (MASTER && fifo_valid && !ctrl.inhibit)
				begin
					st_next  = stes_pkg::ST_RUN;
					sh_next  = fifo_data;
					fifo_pop = 1'b1;
					ss_next  = ~ss_select;
					bit_next = '0;
				end
				else if (!MASTER && ss_edge_on)
				begin
					st_next  = stes_pkg::ST_RUN;
					bit_next = '0;
					// word leaves the queue on the first clock after select
					if (fifo_valid)
					begin
						sh_next  = fifo_data;
						fifo_pop = 1'b1;
					end
					else
					begin
						sh_next = '0;
						isr_next[stes_pkg::IS_UNDERRUN] = 1'b1;
					end
				end
			end
			stes_pkg::ST_RUN:
			begin
				if (MASTER && tick)
					sck_next = !sck_reg;
				if (!MASTER && ss_edge_off)
				begin
					st_next  = stes_pkg::ST_IDLE;
					bit_next = '0;
					sh_next  = '0;
				end
				else
				begin
					// sample and shift on opposite edges so the output bit never moves under the far sample
					if ((ctrl.clock_phase_select ? lead : trail) && bit_reg != '0)
						sh_next = {sh_reg[WIDTH-2:0], in_bit_reg};
					if (ctrl.clock_phase_select ? trail : lead)
					begin
						in_bit_next = MASTER ? miso_i : mosi_s_reg[2];
						bit_next    = bit_reg + BW'(1);
						if (bit_reg == BW'(WIDTH - 1))
						begin
							st_next = stes_pkg::ST_TAIL;
							if (!MASTER)
								div_next = '0;
						end
					end
				end
			end
			stes_pkg::ST_TAIL:
			begin
				// with phase 1 no line edge ends the word, the divider counts it out
				if ((MASTER || ctrl.clock_phase_select) ? tick : trail)
				begin
					word_end = 1'b1;
					st_next  = stes_pkg::ST_IDLE;
					sck_next = 1'b0;
					sh_next  = {sh_reg[WIDTH-2:0], in_bit_reg};
					// automatic select drops after every word so the far side re-frames
					if (MASTER && !ctrl.manual_ss)
						ss_next = '1;
				end
			end
			default:
				st_next = stes_pkg::ST_IDLE;
		endcase
		if (word_end)
		begin
			rdr_next = sh_next;
			occ_next = (occ_next == 5'h1f) ? occ_next : occ_next + 5'h1;
			// with fifos, intermediate words leave the flags alone
			if (!USE_FIFO || first_reg || !fifo_valid)
			begin
				sr_next[stes_pkg::SR_RX_EMPTY] = 1'b0;
				sr_next[stes_pkg::SR_TX_FULL]  = 1'b0;
				sr_next[stes_pkg::SR_TX_EMPTY] = 1'b1;
				sr_next[stes_pkg::SR_RX_FULL]  = 1'b1;
				isr_next[stes_pkg::IS_RX_FULL] = 1'b1;
				isr_next[stes_pkg::IS_DONE]    = 1'b1;
				isr_next[stes_pkg::IS_MODE_FAULT_FLAG]    = !MASTER && ctrl.manual_ss;
				done_next = 1'b1;
			end
			first_next = !fifo_valid;
		end
		if (fifo_valid && st_reg == stes_pkg::ST_IDLE)
			sr_next[stes_pkg::SR_TX_EMPTY] = 1'b0;
		if (!tx_ready)
			sr_next[stes_pkg::SR_TX_FULL] = 1'b1;
		if (tx_half && !half_prev_reg)
			isr_next[stes_pkg::IS_TX_HALF] = 1'b1;
		if (cfg_bad)
			isr_next[stes_pkg::IS_CFG_ERR] = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_reg    <= stes_pkg::ST_IDLE;
			div_reg   <= '0;
			bit_reg   <= '0;
			sck_reg   <= 1'b0;
			sh_reg    <= '0;
			rdr_reg   <= '0;
			sr_reg    <= stes_pkg::SR_RESET;
			isr_reg   <= stes_pkg::IS_RESET;
			ss_reg    <= '1;
			first_reg <= 1'b1;
			in_bit_reg <= 1'b0;
			half_prev_reg <= 1'b1;
			occ_reg   <= '0;
			done_reg  <= 1'b0;
		end
		else
		begin
			st_reg    <= st_next;
			div_reg   <= div_next;
			bit_reg   <= bit_next;
			sck_reg   <= sck_next;
			sh_reg    <= sh_next;
			rdr_reg   <= rdr_next;
			sr_reg    <= sr_next;
			isr_reg   <= isr_next;
			ss_reg    <= ss_next;
			first_reg <= first_next;
			in_bit_reg <= in_bit_next;
			half_prev_reg <= tx_half;
			occ_reg   <= occ_next;
			done_reg  <= done_next;
		end
	end

	// outputs: registers, or single flops behind combinational selects
	logic mosi_q_reg, miso_q_reg, sclk_q_reg, mosi_oe_reg, miso_oe_reg;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mosi_q_reg  <= 1'b0;
			miso_q_reg  <= 1'b0;
			sclk_q_reg  <= 1'b0;
			mosi_oe_reg <= 1'b0;
			miso_oe_reg <= 1'b0;
		end
		else
		begin
			mosi_q_reg  <= sh_next[WIDTH-1];
			miso_q_reg  <= sh_next[WIDTH-1];
			sclk_q_reg  <= sck_next ^ ctrl.clock_polarity_select;
			mosi_oe_reg <= MASTER;
			miso_oe_reg <= !MASTER && st_next != stes_pkg::ST_IDLE;
		end
	end

	always_comb
	begin
		receive_data_register     = rdr_reg;
		serial_status_register    = sr_reg;
		interrupt_status_register = isr_reg;
		rx_occupancy              = occ_reg;
		transfer_done_flag        = done_reg;
		sclk_o                    = sclk_q_reg;
		sclk_oe                   = mosi_oe_reg;
		ss_n_o                    = ss_reg;
		mosi_o                    = mosi_q_reg;
		mosi_oe                   = mosi_oe_reg;
		miso_o                    = miso_q_reg;
		miso_oe                   = miso_oe_reg;
	end

	AST_RX_CAPTURE: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(isr_reg[stes_pkg::IS_RX_FULL]) |-> rdr_reg == $past({sh_reg[WIDTH-2:0], in_bit_reg}))
		else $error("rx word not captured with interrupt");
	AST_STATUS_SYNC: assert property (@(posedge core_clk) disable iff (!rstn)
		done_reg |-> sr_reg[stes_pkg::SR_RX_FULL] && isr_reg[stes_pkg::IS_DONE])
		else $error("status and interrupt bits out of step");
	AST_END_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
		done_reg |-> !sr_reg[stes_pkg::SR_RX_EMPTY])
		else $error("rx empty not cleared at end");
	AST_END_SET: assert property (@(posedge core_clk) disable iff (!rstn)
		done_reg |-> sr_reg[stes_pkg::SR_TX_EMPTY])
		else $error("tx empty not set at end");
	AST_ABORT: assert property (@(posedge core_clk) disable iff (!rstn)
		(!MASTER && st_reg == stes_pkg::ST_RUN && ss_edge_off) |=> st_reg == stes_pkg::ST_IDLE && bit_reg == '0)
		else $error("slave abort failed");
	AST_UNDERRUN: assert property (@(posedge core_clk) disable iff (!rstn)
		(!MASTER && st_reg == stes_pkg::ST_IDLE && ss_edge_on && !fifo_valid) |=> isr_reg[stes_pkg::IS_UNDERRUN])
		else $error("underrun not flagged");
	AST_CFG_ERR: assert property (@(posedge core_clk) disable iff (!rstn)
		cfg_bad |=> isr_reg[stes_pkg::IS_CFG_ERR])
		else $error("bad phase/polarity not flagged");
	AST_TX_HALF: assert property (@(posedge core_clk) disable iff (!rstn)
		(tx_half && !half_prev_reg) |=> isr_reg[stes_pkg::IS_TX_HALF])
		else $error("half empty not flagged");
endmodule

/* rtl/stes_fifo.sv */
// valid/ready fifo with parameter width and depth
`timescale 1ns/1ps
module stes_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("fifo depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      wr_next;
	logic [AW:0]      rd_reg;
	logic [AW:0]      rd_next;
	logic             push;
	logic             pop;

	always_comb
	begin
		in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
		out_valid = wr_reg != rd_reg;
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_next   = wr_reg + (AW+1)'(push);
		rd_next   = rd_reg + (AW+1)'(pop);
		out_data  = mem[rd_reg[AW-1:0]];
		level     = wr_reg - rd_reg;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_reg[AW-1:0]] <= in_data;
	end
endmodule

/* rtl/stes_pkg.sv */
// constants, types and the behaviour list of the transfer-end status block
//
// Behaviour
// - as slave, first tx word is loaded on the first clock after select asserts
// - as slave, a transfer starting with no tx word raises underrun status
// - without fifos, receive-full status bit 1 marks each transfer end
// - received data available sets interrupt status bit 4
// - received word is captured on the same edge as interrupt bit 4 sets
// - master at end clears receive-empty bit 0, transmit-full and bit 3
// - master at end sets transmit-empty bit 2, receive-full bit 1
// - interrupt bits 4 and 1 set on first clock after last sclk; mode fault bit 0 sets only for a slave with manual select
// - with phase 1 the internal clock supplies the missing final edge
// - a counter makes status and interrupt bits change together in both roles; here one word_end strobe sets both
// - with fifos only first and last words flag done; occupancy shows progress
// - transmit fifo reaching half empty raises interrupt bit 6
// - slave role sets and clears the same bits at the same moments
// - word width is 8, 16 or 32, only 8 in dual and quad
// - sclk is the clock divided by a power of two from 2 to 2048
// - 1 to 32 select outputs, exactly one in execute-in-place mode
// - slave role only in standard mode; dual and quad always have the fifo
// - dual and quad fifo depth is 16 or 256 entries of eight bits
// - execute-in-place addressing is 24 or 32 bits
// - performance mode selects the full host port, otherwise the lite one
// - async clock option only when host and serial clocks truly differ; this build rejects the option with an error
// - select bit n drives slave n, active low
// - dual or quad with phase/polarity other than 00 or 11 raises an error
// - slave select released mid-transfer aborts and resets shift and counters
package stes_pkg;
	localparam int SR_RX_EMPTY = 0;
	localparam int SR_RX_FULL  = 1;
	localparam int SR_TX_EMPTY = 2;
	localparam int SR_TX_FULL  = 3;
	localparam int IS_MODE_FAULT_FLAG     = 0;
	localparam int IS_DONE     = 1;
	localparam int IS_UNDERRUN = 3;
	localparam int IS_RX_FULL  = 4;
	localparam int IS_TX_HALF  = 6;
	localparam int IS_CFG_ERR  = 7;
	localparam logic [3:0] SR_RESET = 4'h5;
	localparam logic [7:0] IS_RESET = 8'h00;
	localparam int MODE_STD  = 0;
	localparam int MODE_DUAL = 1;
	localparam int MODE_QUAD = 2;
	localparam int MIN_RATIO = 2;
	localparam int MAX_RATIO = 2048;
	localparam int MAX_SLAVES = 32;

	typedef enum {ST_IDLE, ST_RUN, ST_TAIL} stes_state_t;

	typedef struct packed {
		logic clock_phase_select;
		logic clock_polarity_select;
		logic manual_ss;
		logic inhibit;
	} stes_ctrl_t;
endpackage

/* test/stes_slave_model.sv */
// spi slave model that shifts a reply word out and captures the master word
`timescale 1ns/1ps
module stes_slave_model #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             sclk,
	input  wire logic             ss_n,
	input  wire logic             mosi,
	input  wire logic             clock_phase_select,
	input  wire logic             clock_polarity_select,
	input  wire logic [WIDTH-1:0] reply,
	output logic                  miso,
	output logic [WIDTH-1:0]      got
);
	logic             sclk_d = 1'b0;
	logic             first  = 1'b1;
	logic             last   = 1'b0;
	logic [WIDTH-1:0] sh     = '0;
	logic             rise;
	logic             fall;
	logic             samp;
	logic             drv;
	initial got = '0;
	assign rise = sclk & ~sclk_d;
	assign fall = ~sclk & sclk_d;
	assign samp = (clock_polarity_select == clock_phase_select) ? rise : fall;
	assign drv  = (clock_polarity_select == clock_phase_select) ? fall : rise;
	// released line shows the inverse of the last bit so a stale value cannot pass
	assign miso = ss_n ? ~last : sh[WIDTH-1];
	// everything runs from the system clock, never from sclk itself
	always @(posedge core_clk)
	begin
		sclk_d <= sclk;
		if (ss_n)
		begin
			sh    <= reply;
			first <= 1'b1;
		end
		else
		begin
			last <= sh[WIDTH-1];
			if (samp)
				got <= {got[WIDTH-2:0], mosi};
			else if (drv)
			begin
				// phase 1 presents the first bit on the leading edge, so no shift there
				if (!(clock_phase_select && first))
					sh <= sh << 1;
				first <= 1'b0;
			end
		end
	end
endmodule

/* test/testbench.sv */
// self-checking bench for the transfer-end status core in master build
`timescale 1ns/1ps
module testbench;
	localparam int W     = 8;
	localparam int RATIO = 8;
	typedef struct packed {
		logic [W-1:0] rx;
		logic [W-1:0] tx;
		logic         last;
	} stes_note_t;
	logic                 core_clk  = 1'b0;
	logic                 rstn      = 1'b0;
	stes_pkg::stes_ctrl_t ctrl      = '0;
	logic [0:0]           ss_select = 1'b1;
	logic [W-1:0]         tx_data   = '0;
	logic                 tx_valid  = 1'b0;
	logic                 rx_pop    = 1'b0;
	logic [7:0]           isr_clear = '0;
	logic [W-1:0]         reply     = '0;
	logic                 tx_ready;
	logic [W-1:0]         rdr;
	logic [W-1:0]         got;
	logic [3:0]           sr;
	logic [7:0]           isr;
	logic                 done;
	logic                 sclk;
	logic                 mosi;
	logic                 miso;
	logic [0:0]           ss_n;
	logic [4:0]           occ;
	logic                 sclk_oe;
	logic                 mosi_oe;
	logic                 miso_oe;
	int                   err_count    = 0;
	int                   total_checks = 0;
	stes_note_t           notes[$];
	stes_note_t           nt;

	always #5 core_clk = ~core_clk;

	stes_core #(.WIDTH(W), .RATIO(RATIO)) i_stes_core (
		.core_clk(core_clk), .rstn(rstn), .ctrl(ctrl), .ss_select(ss_select),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_pop(rx_pop),
		.isr_clear(isr_clear), .receive_data_register(rdr), .serial_status_register(sr),
		.interrupt_status_register(isr), .rx_occupancy(occ), .transfer_done_flag(done),
		.sclk_o(sclk), .sclk_oe(sclk_oe), .ss_n_o(ss_n), .mosi_o(mosi), .mosi_oe(mosi_oe),
		.mosi_i(1'b0), .miso_o(), .miso_oe(miso_oe), .miso_i(miso), .sclk_i(1'b0), .ss_n_i(1'b1)
	);

	stes_slave_model #(.WIDTH(W)) i_stes_slave_model (
		.core_clk(core_clk), .sclk(sclk), .ss_n(ss_n[0]), .mosi(mosi), .clock_phase_select(ctrl.clock_phase_select),
		.clock_polarity_select(ctrl.clock_polarity_select), .reply(reply), .miso(miso), .got(got)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one valid-ready push; an idle edge first keeps tx_valid from being driven twice
	task automatic push(input logic [W-1:0] d, input logic last);
		int n;
		@(posedge core_clk);
		notes.push_back('{rx: reply, tx: d, last: last});
		tx_data  <= d;
		tx_valid <= 1'b1;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (tx_ready !== 1'b1 && n < 100);
		@(posedge core_clk);
		tx_valid <= 1'b0;
		check("push_accepted", n < 100, 1);
	endtask

	task automatic clear_all();
		@(posedge core_clk);
		isr_clear <= 8'hff;
		rx_pop    <= 1'b1;
		@(posedge core_clk);
		isr_clear <= 8'h00;
		rx_pop    <= 1'b0;
		@(negedge core_clk);
		check("isr_rx_full_clr", isr[stes_pkg::IS_RX_FULL], 0);
		check("sr_rx_full_pop", sr[stes_pkg::SR_RX_FULL], 0);
		check("sr_rx_empty_pop", sr[stes_pkg::SR_RX_EMPTY], 1);
	endtask

	task automatic one_word(input logic [W-1:0] d);
		int n;
		reply <= W'($urandom);
		push(d, 1'b1);
		n = 0;
		while (ss_n !== 1'b0 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		check("ss_n_o_active", ss_n, 0);
		check("mosi_oe", mosi_oe, 1);
		check("sclk_oe", sclk_oe, 1);
		check("miso_oe", miso_oe, 0);
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(negedge core_clk);
			n++;
		end
		check("done_in_time", n < 400, 1);
		check("word_cycles", n, W * RATIO + (ctrl.clock_phase_select ? RATIO / 2 : 0));
		@(negedge core_clk);
		check("ss_n_o_released", ss_n, 1);
		check("rx_occupancy", occ, 1);
		clear_all();
	endtask

	// compares status at the done cycle: the checked bits must move together with the data, tx empty only on the last word
	always @(posedge core_clk)
	begin
		#1;
		if (rstn && done === 1'b1)
		begin
			if (notes.size() == 0)
				check("unexpected_done", 0, 1);
			else
			begin
				nt = notes.pop_front();
				check("receive_data_register", rdr, nt.rx);
				check("sr_rx_full", sr[stes_pkg::SR_RX_FULL], 1);
				check("sr_rx_empty", sr[stes_pkg::SR_RX_EMPTY], 0);
				check("sr_tx_full", sr[stes_pkg::SR_TX_FULL], 0);
				if (nt.last)
					check("sr_tx_empty", sr[stes_pkg::SR_TX_EMPTY], 1);
				check("isr_rx_full", isr[stes_pkg::IS_RX_FULL], 1);
				check("isr_done", isr[stes_pkg::IS_DONE], 1);
				check("slave_got_word", got, nt.tx);
			end
		end
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("Error watchdog expected finish seen timeout");
		tally_and_finish();
	end

	initial
	begin
		int n;
		reply = W'($urandom(32'h706b));
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		check("sr_reset", sr, stes_pkg::SR_RESET);
		check("isr_reset", isr, stes_pkg::IS_RESET);
		check("ss_n_o_reset", ss_n, 1);
		for (int m = 0; m < 4; m++)
		begin
			@(posedge core_clk);
			ctrl.clock_phase_select <= m[0];
			ctrl.clock_polarity_select <= m[1];
			repeat (3) one_word(W'($urandom));
		end
		// fill the 8 word buffer while inhibited, then drain it back to back
		@(posedge core_clk);
		ctrl.inhibit <= 1'b1;
		reply        <= W'($urandom);
		for (int i = 0; i < 8; i++)
			push(W'($urandom), i == 7);
		@(negedge core_clk);
		check("tx_ready_full", tx_ready, 0);
		@(negedge core_clk);
		check("sr_tx_full_set", sr[stes_pkg::SR_TX_FULL], 1);
		@(posedge core_clk);
		ctrl.inhibit <= 1'b0;
		n = 0;
		while (notes.size() > 0 && n < 2000)
		begin
			@(negedge core_clk);
			n++;
		end
		check("drain_done", n < 2000, 1);
		check("rx_occ_drain", occ, 8);
		check("isr_tx_half", isr[stes_pkg::IS_TX_HALF], 1);
		clear_all();
		tally_and_finish();
	end
endmodule
